// ===== src/rmc_regs.sv
// Miscellaneous radio configuration register bank with settle timer
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module rmc_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Register access from the serial engine
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Bits of the analog and main control registers
    input wire logic write_unlock,
    input wire logic id_read_en,
    input wire logic manual_synth,
    input wire logic pll_lock_used,
    // Per-chip identifier from fuses
    input wire logic [rmc_pkg::RMC_ID_BITS-1:0] chip_id,
    // Configuration towards the radio
    output logic power_save,
    output logic carrier_override,
    output logic [7:0] clk_override,
    output logic [7:0] clk_gating,
    // Synthesizer settle timer
    input wire logic synth_start,
    output logic settle_busy,
    output logic settle_done
);
    import rmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    logic wr_pwr;
    logic wr_cs;
    logic wr_ovr;
    logic wr_gate;
    logic wr_settle;
    logic id_hit;
    assign wr_pwr = reg_wr && (reg_addr == RMC_ADDR_PWR_SAVE) && write_unlock;
    assign wr_cs = reg_wr && (reg_addr == RMC_ADDR_CS_OVR) && write_unlock;
    assign wr_ovr = reg_wr && (reg_addr == RMC_ADDR_CLK_OVR);
    assign wr_gate = reg_wr && (reg_addr == RMC_ADDR_CLK_GATE);
    assign wr_settle = reg_wr && (reg_addr == RMC_ADDR_SETTLE);
    assign id_hit = (reg_addr >= RMC_ADDR_ID_B0) && (reg_addr <= RMC_ADDR_ID_B3);

    ////////////////////////////////////////////////////////////////////////
    // Storage; only the flag bit of the gated registers is kept
    logic pwr_r;
    logic cs_r;
    logic [7:0] ovr_r;
    logic [7:0] gate_r;
    logic [7:0] settle_r;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pwr_r <= RMC_RST_PWR_SAVE[RMC_FLAG_BIT];
            cs_r <= RMC_RST_CS_OVR[RMC_FLAG_BIT];
            ovr_r <= RMC_RST_CLK_OVR;
            gate_r <= RMC_RST_CLK_GATE;
            settle_r <= RMC_RST_SETTLE;
        end else begin
            if (wr_pwr) begin
                pwr_r <= reg_wdata[RMC_FLAG_BIT];
            end
            if (wr_cs) begin
                cs_r <= reg_wdata[RMC_FLAG_BIT];
            end
            if (wr_ovr) begin
                ovr_r <= reg_wdata;
            end
            if (wr_gate) begin
                gate_r <= reg_wdata;
            end
            if (wr_settle) begin
                settle_r <= reg_wdata;
            end
        end
    end

    // Outputs straight from the storage flops
    assign power_save = pwr_r;
    assign carrier_override = cs_r;
    assign clk_override = ovr_r;
    assign clk_gating = gate_r;

    ////////////////////////////////////////////////////////////////////////
    // Identifier synchroniser; fuse levels are async to the clock
    logic [RMC_ID_BITS-1:0] id_s1_r;
    logic [RMC_ID_BITS-1:0] id_s2_r;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            id_s1_r <= '0;
            id_s2_r <= '0;
        end else begin
            id_s1_r <= chip_id;
            id_s2_r <= id_s1_r;
        end
    end

    // Identifier word, top two bits forced low
    logic [31:0] id_word;
    assign id_word = {2'b00, id_s2_r};

    // Byte select of the identifier, highest address is the top byte
    function automatic logic [7:0] id_byte(input logic [31:0] w, input logic [1:0] sel);
        id_byte = w[8*sel +: 8];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Read mux; identifier is blanked while not enabled to save power
    logic [7:0] rd_mux;
    logic [7:0] id_sel;
    assign id_sel = id_read_en ? id_byte(id_word, reg_addr[1:0]) : 8'h00;
    assign rd_mux =
        (reg_addr == RMC_ADDR_PWR_SAVE) ? {pwr_r, 7'h00} :
        (reg_addr == RMC_ADDR_CS_OVR) ? {cs_r, 7'h00} :
        (reg_addr == RMC_ADDR_CLK_OVR) ? ovr_r :
        (reg_addr == RMC_ADDR_CLK_GATE) ? gate_r :
        (reg_addr == RMC_ADDR_SETTLE) ? settle_r :
        id_hit ? id_sel : 8'h00;

    // Read data held until the next read
    logic [7:0] rdata_r;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end
    end
    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Settle timer: step counter and count of remaining steps
    rmc_state_e state_r;
    rmc_state_e state_nxt;
    logic [6:0] tick_r;
    logic [6:0] tick_nxt;
    logic [7:0] steps_r;
    logic [7:0] steps_nxt;
    logic done_r;
    logic done_nxt;
    logic apply_delay;
    logic step_end;
    assign apply_delay = !manual_synth && !pll_lock_used;
    assign step_end = (tick_r == RMC_STEP_LAST);

    // Next-state logic; the step count is latched at start
    always_comb begin
        state_nxt = state_r;
        tick_nxt = tick_r;
        steps_nxt = steps_r;
        done_nxt = 1'b0;
        unique case (state_r)
            RMC_IDLE: begin
                if (synth_start) begin
                    if (apply_delay && settle_r != 8'h00) begin
                        state_nxt = RMC_WAIT;
                        tick_nxt = 7'h00;
                        steps_nxt = settle_r;
                    end else begin
                        done_nxt = 1'b1;
                    end
                end
            end
            RMC_WAIT: begin
                if (step_end) begin
                    tick_nxt = 7'h00;
                    steps_nxt = steps_r - 8'h01;
                    if (steps_r == 8'h01) begin
                        state_nxt = RMC_IDLE;
                        done_nxt = 1'b1;
                    end
                end else begin
                    tick_nxt = tick_r + 7'h01;
                end
            end
        endcase
    end

    // Timer flops
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= RMC_IDLE;
            tick_r <= 7'h00;
            steps_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tick_r <= tick_nxt;
            steps_r <= steps_nxt;
            done_r <= done_nxt;
        end
    end
    assign settle_busy = (state_r == RMC_WAIT);
    assign settle_done = done_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks; helper counts cycles spent waiting
    logic [15:0] wait_cnt_r;
    logic [15:0] wait_len_r;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_cnt_r <= 16'h0000;
            wait_len_r <= 16'h0000;
        end else if (state_r == RMC_IDLE && state_nxt == RMC_WAIT) begin
            wait_cnt_r <= 16'h0001;
            wait_len_r <= 16'(settle_r) * 16'(RMC_STEP_CYC);
        end else if (settle_busy) begin
            wait_cnt_r <= wait_cnt_r + 16'h0001;
        end
    end

    save_gate_a: assert property (@(posedge clock) disable iff (!nrst)
        reg_wr && reg_addr == RMC_ADDR_PWR_SAVE && !write_unlock |=> $stable(power_save))
        else $error("power save changed while locked");
    save_write_a: assert property (@(posedge clock) disable iff (!nrst)
        reg_wr && reg_addr == RMC_ADDR_PWR_SAVE && write_unlock
        |=> power_save == $past(reg_wdata[7]))
        else $error("power save did not take written bit");
    cs_gate_a: assert property (@(posedge clock) disable iff (!nrst)
        reg_wr && reg_addr == RMC_ADDR_CS_OVR && !write_unlock |=> $stable(carrier_override))
        else $error("carrier override changed while locked");
    cs_write_a: assert property (@(posedge clock) disable iff (!nrst)
        reg_wr && reg_addr == RMC_ADDR_CS_OVR && write_unlock
        |=> carrier_override == $past(reg_wdata[7]))
        else $error("carrier override did not take written bit");
    settle_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        !(reg_wr && reg_addr == RMC_ADDR_SETTLE) |=> $stable(settle_r))
        else $error("settle count changed without a write");
    settle_len_a: assert property (@(posedge clock) disable iff (!nrst)
        settle_busy && state_nxt == RMC_IDLE |-> wait_cnt_r == wait_len_r)
        else $error("settle wait length wrong");
    settle_bypass_a: assert property (@(posedge clock) disable iff (!nrst)
        !settle_busy && synth_start && !apply_delay |=> settle_done && !settle_busy)
        else $error("bypassed start did not finish at once");
    id_top_a: assert property (@(posedge clock) disable iff (!nrst)
        reg_rd && reg_addr == RMC_ADDR_ID_B3 |=> reg_rdata[7:6] == 2'b00)
        else $error("identifier top bits not zero");
    id_blank_a: assert property (@(posedge clock) disable iff (!nrst)
        reg_rd && id_hit && !id_read_en |=> reg_rdata == 8'h00)
        else $error("identifier visible while disabled");

    ////////////////////////////////////////////////////////////////////////
    // Settle timer checks; the helper count above gives the wait length

    // A delayed start raises busy on the next cycle
    settle_start_a: assert property (@(posedge clock) disable iff (!nrst)
        !settle_busy && synth_start && apply_delay && settle_r != 8'h00
        |=> settle_busy)
        else $error("delayed start did not raise busy");

    // Starts while busy are ignored, so busy may only end on a step boundary
    busy_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        settle_busy && !step_end
        |=> settle_busy)
        else $error("settle wait ended inside a step");

    // The last step ends with one done pulse and busy low
    settle_end_a: assert property (@(posedge clock) disable iff (!nrst)
        settle_busy && state_nxt == RMC_IDLE
        |=> settle_done && !settle_busy)
        else $error("settle wait did not end with done");

    // Done and busy never stand together
    done_idle_a: assert property (@(posedge clock) disable iff (!nrst)
        settle_done
        |-> !settle_busy)
        else $error("done raised while still busy");

    ////////////////////////////////////////////////////////////////////////
    // Identifier checks

    // The lowest byte address returns the low identifier byte
    id_low_a: assert property (@(posedge clock) disable iff (!nrst)
        reg_rd && reg_addr == RMC_ADDR_ID_B0 && id_read_en
        |=> reg_rdata == $past(id_s2_r[7:0]))
        else $error("identifier low byte misplaced");

    // Identifier writes reach no storage; decode aliasing would show here
    id_write_a: assert property (@(posedge clock) disable iff (!nrst)
        reg_wr && id_hit
        |=> $stable(power_save) && $stable(carrier_override) && $stable(clk_override)
            && $stable(clk_gating) && $stable(settle_r))
        else $error("identifier write changed a register");
endmodule

// ===== include/rmc_pkg.sv
// Register map, reset values and timing constants of the radio config bank
package rmc_pkg;
    // Byte addresses of the register bank
    localparam logic [5:0] RMC_ADDR_PWR_SAVE = 6'h2E;
    localparam logic [5:0] RMC_ADDR_CS_OVR = 6'h2F;
    localparam logic [5:0] RMC_ADDR_CLK_OVR = 6'h32;
    localparam logic [5:0] RMC_ADDR_CLK_GATE = 6'h33;
    localparam logic [5:0] RMC_ADDR_SETTLE = 6'h38;
    localparam logic [5:0] RMC_ADDR_ID_B0 = 6'h3C;
    localparam logic [5:0] RMC_ADDR_ID_B3 = 6'h3F;
    localparam logic [3:0] RMC_ID_BASE_HI = 4'hF;
    // Field positions
    localparam int RMC_FLAG_BIT = 7;
    localparam int RMC_ID_BITS = 30;
    // Reset values
    localparam logic [7:0] RMC_RST_PWR_SAVE = 8'h00;
    localparam logic [7:0] RMC_RST_CS_OVR = 8'h00;
    localparam logic [7:0] RMC_RST_CLK_OVR = 8'h00;
    localparam logic [7:0] RMC_RST_CLK_GATE = 8'h00;
    localparam logic [7:0] RMC_RST_SETTLE = 8'h64;
    // Timing: one settle step and the clock period
    localparam int RMC_STEP_NS = 2000;
    localparam int RMC_CLK_NS = 25;
    localparam int RMC_STEP_CYC = RMC_STEP_NS / RMC_CLK_NS;
    localparam logic [6:0] RMC_STEP_LAST = 7'(RMC_STEP_CYC - 1);
    // Settle timer states
    typedef enum logic [0:0] {
        RMC_IDLE = 1'b0,
        RMC_WAIT = 1'b1
    } rmc_state_e;
endpackage

// ===== bench/rmc_host_model.sv
// Host controller model driving the register strobe port and control levels
`timescale 1ns/1ps
module rmc_host_model (
    // Clock
    input wire logic clock,
    // Register strobe port
    output logic reg_wr,
    output logic reg_rd,
    output logic [5:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Control register levels
    output logic write_unlock,
    output logic id_read_en,
    output logic manual_synth,
    output logic pll_lock_used,
    output logic synth_start
);
    // Quiet bus at time zero
    initial begin
        {reg_wr, reg_rd, write_unlock, id_read_en, manual_synth, pll_lock_used} = 6'h00;
        synth_start = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data flips after release so a stale value is never read as held
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask

    // Read data sampled one edge after the strobe is taken
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        #1 d = reg_rdata;
    endtask

    // Unlock, identifier enable, manual synth, lock signal in use
    task automatic lv(input logic [3:0] v);
        @(posedge clock);
        {write_unlock, id_read_en, manual_synth, pll_lock_used} <= v;
    endtask

    // One start pulse for the settle wait
    task automatic start();
        @(posedge clock);
        synth_start <= 1'b1;
        @(posedge clock);
        synth_start <= 1'b0;
    endtask

    // Start-up sequence; caller has set the unlock level first
    task automatic init();
        wr(6'h2E, 8'h80);
        wr(6'h32, 8'h41);
        wr(6'h33, 8'h41);
    endtask
endmodule

// ===== bench/radio_misc_config_registers_tb.sv
// Self-checking bench for the radio configuration register bank
`timescale 1ns/1ps
module radio_misc_config_registers_tb;
    import rmc_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr, reg_rd, write_unlock, id_read_en, manual_synth, pll_lock_used, synth_start;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, clk_override, clk_gating, d;
    logic power_save, carrier_override, settle_busy, settle_done;
    logic [29:0] chip_id = 30'h2A5C_3E71;
    logic [31:0] id_exp;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int n, nb;

    // 40 MHz clock
    always #12.5 clock = ~clock;

    rmc_regs u_rmc_regs (.clock(clock), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .write_unlock(write_unlock), .id_read_en(id_read_en), .manual_synth(manual_synth),
        .pll_lock_used(pll_lock_used), .chip_id(chip_id), .power_save(power_save),
        .carrier_override(carrier_override), .clk_override(clk_override),
        .clk_gating(clk_gating), .synth_start(synth_start), .settle_busy(settle_busy),
        .settle_done(settle_done));

    rmc_host_model u_rmc_host_model (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .write_unlock(write_unlock), .id_read_en(id_read_en), .manual_synth(manual_synth),
        .pll_lock_used(pll_lock_used), .synth_start(synth_start));

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        u_rmc_host_model.rd(a, d);
        check(d, e);
    endtask

    // Counts edges from the taken start to done, and busy cycles before it
    task automatic settle(input int exp_n, input int exp_b);
        n = 0;
        nb = 0;
        u_rmc_host_model.start();
        #1;
        while (settle_done !== 1'b1 && n < 400) begin
            if (settle_busy === 1'b1) nb++;
            @(posedge clock);
            #1;
            n++;
        end
        check(n, exp_n);
        check(nb, exp_b);
    endtask

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        rchk(6'h2E, 8'h00);
        rchk(6'h2F, 8'h00);
        rchk(6'h32, 8'h00);
        rchk(6'h33, 8'h00);
        rchk(6'h38, 8'h64);
        rchk(6'h00, 8'h00);
        $display("test reset values done");
        // Locked writes must be dropped
        u_rmc_host_model.wr(6'h2E, 8'h80);
        u_rmc_host_model.wr(6'h2F, 8'h80);
        rchk(6'h2E, 8'h00);
        rchk(6'h2F, 8'h00);
        check(power_save, 1'b0);
        u_rmc_host_model.lv(4'b1000);
        u_rmc_host_model.init();
        u_rmc_host_model.wr(6'h2F, 8'h80);
        rchk(6'h2E, 8'h80);
        rchk(6'h2F, 8'h80);
        rchk(6'h33, 8'h41);
        check(power_save, 1'b1);
        check(carrier_override, 1'b1);
        check(clk_override, 8'h41);
        check(clk_gating, 8'h41);
        $display("test gated and clock registers done");
        // Identifier hidden, then read byte by byte, then written in vain
        id_exp = {2'b00, chip_id};
        rchk(6'h3C, 8'h00);
        u_rmc_host_model.lv(4'b1100);
        for (int i = 0; i < 4; i++) begin
            rchk(6'h3C + 6'(i), id_exp[8*i+:8]);
        end
        u_rmc_host_model.wr(6'h3F, 8'hFF);
        rchk(6'h3F, id_exp[31:24]);
        u_rmc_host_model.lv(4'b1000);
        $display("test identifier done");
        // Settle wait in auto mode, manual mode and lock-signal mode
        u_rmc_host_model.wr(6'h38, 8'h02);
        rchk(6'h38, 8'h02);
        settle(2 * RMC_STEP_CYC, 2 * RMC_STEP_CYC);
        u_rmc_host_model.lv(4'b1010);
        settle(0, 0);
        u_rmc_host_model.lv(4'b1001);
        settle(0, 0);
        $display("test settle timer done");
        stop_test();
    end
endmodule
